// ---- hdl/peak_monitor.sv ----
// How it works
// - one independent counter per channel, input strength or overflows.
// - mode field zero in monitor control watches input magnitude.
// - threshold selects quarter, half, three quarters or full scale.
// - input mode counts each sample whose magnitude reaches the threshold.
// - mode one counts overflows at the point chosen in overflow select.
// - each overflow at the selected point counts; any stage overflow saturates its data to signed full scale.
// - counter stops at 255 and holds until cleared.
// - selected sync copies count to holding register and restarts counter, counting an event in the sync cycle as its first.
// - sync source is an input sync, one-shot pulse or terminal count.
// - captured count is readable at the count register address.
// - holding value moves to readable register one cycle after its read.
// - resampler input sum overflow saturates and sets sticky status flag.
// - writing zero clears the flag; it stays low until a new overflow.
`timescale 1ns/10ps
`default_nettype none
module peak_monitor
  import peak_mon_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // control port
  input wire ctrl_req_t req_in,
  output logic [7:0] rdata_out,
  // channel input sample
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  // gain and filter stage values, inputs before saturation and outputs after
  input wire stage_in_t coarse_in,
  input wire stage_in_t comp_in,
  input wire stage_in_t prog_in,
  output stage_out_t coarse_out,
  output stage_out_t comp_out,
  output stage_out_t prog_out,
  // resampler input adder
  input wire logic res_valid_in,
  input wire logic [RES_W-1:0] res_a_in,
  input wire logic [RES_W-1:0] res_b_in,
  output logic res_valid_out,
  output logic [RES_W-1:0] res_sum_out,
  // sync sources
  input wire logic sync_pin_a_in,
  input wire logic sync_pin_b_in,
  input wire logic one_shot_in,
  input wire logic terminal_count_in
);
  //////////////////////////////////////////////////////////////////////
  function automatic logic stage_ovf(input logic [STAGE_W-1:0] x);
    stage_ovf = !((&x[STAGE_W-1:SAMPLE_W-1]) || !(|x[STAGE_W-1:SAMPLE_W-1]));
  endfunction

  function automatic stage_out_t stage_sat(input stage_in_t x);
    stage_sat.valid = x.valid;
    if (stage_ovf(x.data)) begin
      stage_sat.data = x.data[STAGE_W-1] ? NEG_FULL : POS_FULL;
    end else begin
      stage_sat.data = x.data[SAMPLE_W-1:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ovf_sel_q, ovf_sel_d, mon_ctrl_q, mon_ctrl_d;
  logic [7:0] readable_q, readable_d, rdata_q, rdata_d;
  logic xfer_q, xfer_d, flag_q, flag_d;
  logic [7:0] hold;
  logic rd_count, res_ovf;
  logic [RES_W:0] res_sum;

  assign rd_count = req_in.rd && req_in.addr == ADDR_COUNT;

  always_comb begin
    ovf_sel_d = ovf_sel_q;
    mon_ctrl_d = mon_ctrl_q;
    rdata_d = rdata_q;
    flag_d = flag_q;
    xfer_d = rd_count;
    // late transfer so a read never meets an update
    readable_d = xfer_q ? hold : readable_q;
    if (req_in.wr) begin
      case (req_in.addr)
        ADDR_OVF_SEL: ovf_sel_d = req_in.wdata;
        ADDR_MON_CTRL: mon_ctrl_d = req_in.wdata;
        ADDR_STATUS: begin
          if (!req_in.wdata[STAT_RES_OVF_BIT]) begin
            flag_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // new overflow wins over a clear in the same cycle
    if (res_ovf) begin
      flag_d = 1'b1;
    end
    if (req_in.rd) begin
      case (req_in.addr)
        ADDR_STATUS: rdata_d = {7'h00, flag_q};
        ADDR_OVF_SEL: rdata_d = ovf_sel_q;
        ADDR_MON_CTRL: rdata_d = mon_ctrl_q;
        ADDR_COUNT: rdata_d = readable_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ovf_sel_q <= CTRL_RESET;
      mon_ctrl_q <= CTRL_RESET;
      readable_q <= COUNT_RESET;
      rdata_q <= 8'h00;
      xfer_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      ovf_sel_q <= ovf_sel_d;
      mon_ctrl_q <= mon_ctrl_d;
      readable_q <= readable_d;
      rdata_q <= rdata_d;
      xfer_q <= xfer_d;
      flag_q <= flag_d;
    end
  end

  assign rdata_out = rdata_q;

  //////////////////////////////////////////////////////////////////////
  // saturation stages
  stage_out_t coarse_q, comp_q, prog_q;
  logic res_valid_q;
  logic [RES_W-1:0] res_sum_q, res_sat;

  assign res_sum = {res_a_in[RES_W-1], res_a_in} +
    {res_b_in[RES_W-1], res_b_in};
  assign res_ovf = res_valid_in && (res_sum[RES_W] != res_sum[RES_W-1]);
  assign res_sat = (res_sum[RES_W] != res_sum[RES_W-1]) ?
    (res_sum[RES_W] ? RES_NEG_FULL : RES_POS_FULL) :
    res_sum[RES_W-1:0];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      coarse_q <= '0;
      comp_q <= '0;
      prog_q <= '0;
      res_valid_q <= 1'b0;
      res_sum_q <= '0;
    end else begin
      coarse_q <= stage_sat(coarse_in);
      comp_q <= stage_sat(comp_in);
      prog_q <= stage_sat(prog_in);
      res_valid_q <= res_valid_in;
      res_sum_q <= res_sat;
    end
  end

  assign coarse_out = coarse_q;
  assign comp_out = comp_q;
  assign prog_out = prog_q;
  assign res_valid_out = res_valid_q;
  assign res_sum_out = res_sum_q;

  //////////////////////////////////////////////////////////////////////
  // event selection
  logic [SAMPLE_W:0] mag;
  logic [16:0] thresh;
  logic in_event, ovf_event, inc;

  assign mag = sample_in[SAMPLE_W-1] ?
    (17'h00000 - {sample_in[SAMPLE_W-1], sample_in}) : {1'b0, sample_in};

  always_comb begin
    case (mon_ctrl_q[THRESH_LSB +: 2])
      2'h0: thresh = TH_QUARTER;
      2'h1: thresh = TH_HALF;
      2'h2: thresh = TH_3QUARTER;
      default: thresh = TH_FULL;
    endcase
  end

  assign in_event = sample_valid_in && mag >= thresh;

  always_comb begin
    case (ovf_sel_q[OVF_SEL_LSB +: 2])
      PT_COARSE: ovf_event = coarse_in.valid && stage_ovf(coarse_in.data);
      PT_COMP: ovf_event = comp_in.valid && stage_ovf(comp_in.data);
      PT_PROG: ovf_event = prog_in.valid && stage_ovf(prog_in.data);
      default: ovf_event = 1'b0;
    endcase
  end

  assign inc = (mon_ctrl_q[MODE_BIT] == MODE_INPUT) ?
    in_event : ovf_event;

  //////////////////////////////////////////////////////////////////////
  // sync pins: two flops, then an edge stage
  logic [2:0] pa_q, pa_d, pb_q, pb_d;
  logic sync_sel;

  always_comb begin
    pa_d = {pa_q[1:0], sync_pin_a_in};
    pb_d = {pb_q[1:0], sync_pin_b_in};
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pa_q <= 3'h0;
      pb_q <= 3'h0;
    end else begin
      pa_q <= pa_d;
      pb_q <= pb_d;
    end
  end

  always_comb begin
    case (mon_ctrl_q[SYNC_SEL_LSB +: 2])
      SYNC_PIN_A: sync_sel = pa_q[1] && !pa_q[2];
      SYNC_PIN_B: sync_sel = pb_q[1] && !pb_q[2];
      SYNC_ONE_SHOT: sync_sel = one_shot_in;
      default: sync_sel = terminal_count_in;
    endcase
  end

  // one counter per channel instance
  peak_event_counter u_cnt (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .inc_in(inc),
    .sync_in(sync_sel),
    .hold_out(hold)
  );

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_xfer;
    rd_count |-> ##2 readable_q == $past(hold, 1);
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("readable count not loaded after read");

  property p_rdata;
    rd_count |=> rdata_out == $past(readable_q);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("count read returned wrong value");

  property p_flag_set;
    res_ovf |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("resampler overflow flag not set");

  property p_flag_clear;
    req_in.wr && req_in.addr == ADDR_STATUS && !req_in.wdata[0] && !res_ovf
      ##1 !res_ovf [*2] |-> !flag_q ##1 !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag did not stay clear");

  property p_res_sat;
    res_ovf |=> res_sum_out == RES_POS_FULL || res_sum_out == RES_NEG_FULL;
  endproperty
  a_res_sat: assert property (p_res_sat)
    else $error("resampler sum not saturated");

  property p_coarse_sat;
    coarse_in.valid && stage_ovf(coarse_in.data) |=>
      coarse_out.data ==
        ($past(coarse_in.data[STAGE_W-1]) ? NEG_FULL : POS_FULL);
  endproperty
  a_coarse_sat: assert property (p_coarse_sat)
    else $error("coarse stage not saturated to signed full scale");

  property p_input_mode;
    // most negative sample reaches every threshold, so only valid decides
    mon_ctrl_q[MODE_BIT] == MODE_INPUT && sample_in == NEG_FULL |->
      inc == sample_valid_in;
  endproperty
  a_input_mode: assert property (p_input_mode)
    else $error("input mode event mismatch");

  property p_ovf_mode;
    mon_ctrl_q[MODE_BIT] == MODE_OVERFLOW && ovf_sel_q[1:0] == PT_PROG |->
      inc == (prog_in.valid &&
        !(prog_in.data[STAGE_W-1:SAMPLE_W-1] inside {5'h00, 5'h1F}));
  endproperty
  a_ovf_mode: assert property (p_ovf_mode)
    else $error("overflow mode event mismatch");
endmodule // peak_monitor
`default_nettype wire

// ---- hdl/peak_mon_pkg.sv ----
`default_nettype none
package peak_mon_pkg;
  // control port addresses
  localparam logic [4:0] ADDR_STATUS = 5'h01;
  localparam logic [4:0] ADDR_OVF_SEL = 5'h1A;
  localparam logic [4:0] ADDR_MON_CTRL = 5'h1C;
  localparam logic [4:0] ADDR_COUNT = 5'h1D;
  // field positions
  localparam int STAT_RES_OVF_BIT = 0;
  localparam int MODE_BIT = 0;
  localparam int THRESH_LSB = 1;
  localparam int SYNC_SEL_LSB = 3;
  localparam int OVF_SEL_LSB = 0;
  // reset values and counter maximum
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  // data widths
  localparam int SAMPLE_W = 16;
  localparam int STAGE_W = 20;
  localparam int RES_W = 24;
  // magnitude thresholds, 17-bit magnitude of a 16-bit sample
  localparam logic [16:0] TH_QUARTER = 17'h02000;
  localparam logic [16:0] TH_HALF = 17'h04000;
  localparam logic [16:0] TH_3QUARTER = 17'h06000;
  localparam logic [16:0] TH_FULL = 17'h07FFF;
  // saturation limits
  localparam logic [15:0] POS_FULL = 16'h7FFF;
  localparam logic [15:0] NEG_FULL = 16'h8000;
  localparam logic [23:0] RES_POS_FULL = 24'h7FFFFF;
  localparam logic [23:0] RES_NEG_FULL = 24'h800000;
  // monitor mode, overflow point and sync source encodings
  localparam logic MODE_INPUT = 1'b0;
  localparam logic MODE_OVERFLOW = 1'b1;
  localparam logic [1:0] PT_COARSE = 2'h0;
  localparam logic [1:0] PT_COMP = 2'h1;
  localparam logic [1:0] PT_PROG = 2'h2;
  localparam logic [1:0] SYNC_PIN_A = 2'h0;
  localparam logic [1:0] SYNC_PIN_B = 2'h1;
  localparam logic [1:0] SYNC_ONE_SHOT = 2'h2;
  localparam logic [1:0] SYNC_TERMINAL = 2'h3;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ctrl_req_t;

  typedef struct packed {
    logic valid;
    logic [STAGE_W-1:0] data;
  } stage_in_t;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } stage_out_t;
endpackage
`default_nettype wire

// ---- hdl/peak_event_counter.sv ----
`timescale 1ns/10ps
`default_nettype none
module peak_event_counter
  import peak_mon_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // events
  input wire logic inc_in,
  input wire logic sync_in,
  // captured value
  output logic [7:0] hold_out
);
  logic [7:0] cnt_q, cnt_d, hold_q, hold_d;

  always_comb begin
    cnt_d = cnt_q;
    hold_d = hold_q;
    if (sync_in) begin
      hold_d = cnt_q;
      // an event in the sync cycle opens the new period
      cnt_d = inc_in ? 8'h01 : COUNT_RESET;
    end else if (inc_in && cnt_q != COUNT_MAX) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= COUNT_RESET;
      hold_q <= COUNT_RESET;
    end else begin
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end

  assign hold_out = hold_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_cnt_step;
    inc_in && !sync_in && cnt_q != COUNT_MAX |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter did not step on event");

  property p_cnt_stop;
    cnt_q == COUNT_MAX && !sync_in |=> cnt_q == COUNT_MAX;
  endproperty
  a_cnt_stop: assert property (p_cnt_stop)
    else $error("counter left its maximum without sync");

  property p_capture;
    sync_in |=> hold_q == $past(cnt_q) && cnt_q == {7'h00, $past(inc_in)};
  endproperty
  a_capture: assert property (p_capture)
    else $error("sync did not capture and clear");

  property p_hold_steady;
    !sync_in |=> $stable(hold_q);
  endproperty
  a_hold_steady: assert property (p_hold_steady)
    else $error("holding register moved without sync");
endmodule // peak_event_counter
`default_nettype wire

// ---- test/tb_peak_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_peak_monitor;
  import peak_mon_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] osel;
    logic [1:0] pt;
    logic [19:0] val;
    logic [8:0] n;
    logic [7:0] cnt;
  } row_t;
  localparam int N_ROWS = 15;
  // whole run needs under 2000 cycles
  localparam int LIMIT = 5000;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  ctrl_req_t req_in = '0;
  logic [7:0] rdata_out;
  logic sample_valid_in = 1'b0;
  logic [SAMPLE_W-1:0] sample_in = '0;
  stage_in_t coarse_in = '0;
  stage_in_t comp_in = '0;
  stage_in_t prog_in = '0;
  stage_out_t coarse_out;
  stage_out_t comp_out;
  stage_out_t prog_out;
  logic res_valid_in = 1'b0;
  logic [RES_W-1:0] res_a_in = '0;
  logic [RES_W-1:0] res_b_in = '0;
  logic res_valid_out;
  logic [RES_W-1:0] res_sum_out;
  logic sync_pin_a_in = 1'b0;
  logic sync_pin_b_in = 1'b0;
  logic one_shot_in = 1'b0;
  logic terminal_count_in = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] got;
  logic [7:0] prev = 8'h00;
  row_t rows [N_ROWS];

  always #10 mclk_in = ~mclk_in;

  peak_monitor uut (
    .mclk_in(mclk_in), .rst_in(rst_in), .req_in(req_in),
    .rdata_out(rdata_out), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .coarse_in(coarse_in), .comp_in(comp_in),
    .prog_in(prog_in), .coarse_out(coarse_out), .comp_out(comp_out),
    .prog_out(prog_out), .res_valid_in(res_valid_in),
    .res_a_in(res_a_in), .res_b_in(res_b_in),
    .res_valid_out(res_valid_out), .res_sum_out(res_sum_out),
    .sync_pin_a_in(sync_pin_a_in), .sync_pin_b_in(sync_pin_b_in),
    .one_shot_in(one_shot_in), .terminal_count_in(terminal_count_in)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check8(input logic [7:0] seen, input logic [7:0] exp);
    check({16'h0000, seen}, {16'h0000, exp});
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    req_in <= '0;
  endtask

  // read data lands on the edge that takes rd
  task automatic rd(input logic [4:0] a);
    @(posedge mclk_in);
    req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req_in <= '0;
    #1 got = rdata_out;
  endtask

  // pins need three edges through the synchroniser, so wait four
  task automatic do_sync(input logic [1:0] src);
    @(posedge mclk_in);
    sync_pin_a_in <= (src == SYNC_PIN_A);
    sync_pin_b_in <= (src == SYNC_PIN_B);
    one_shot_in <= (src == SYNC_ONE_SHOT);
    terminal_count_in <= (src == SYNC_TERMINAL);
    @(posedge mclk_in);
    {sync_pin_a_in, sync_pin_b_in, one_shot_in, terminal_count_in} <= 4'h0;
    repeat (4) @(posedge mclk_in);
  endtask

  // same data on every stage, only the chosen one marked valid
  task automatic feed(input logic [1:0] pt, input logic [19:0] v,
                      input int n);
    repeat (n) begin
      @(posedge mclk_in);
      coarse_in <= '{valid: pt == 2'h0, data: v};
      comp_in <= '{valid: pt == 2'h1, data: v};
      prog_in <= '{valid: pt == 2'h2, data: v};
      sample_valid_in <= (pt == 2'h3);
      sample_in <= v[15:0];
    end
    @(posedge mclk_in);
    coarse_in <= '0;
    comp_in <= '0;
    prog_in <= '0;
    sample_valid_in <= 1'b0;
  endtask

  task automatic sat(input logic [19:0] v, input logic [15:0] e);
    @(posedge mclk_in);
    coarse_in <= '{1'b1, v};
    comp_in <= '{1'b1, v};
    prog_in <= '{1'b1, v};
    @(posedge mclk_in);
    coarse_in <= '0;
    comp_in <= '0;
    prog_in <= '0;
    #1;
    check(24'(coarse_out), {7'h00, 1'b1, e});
    check(24'(comp_out), {7'h00, 1'b1, e});
    check(24'(prog_out), {7'h00, 1'b1, e});
  endtask

  task automatic res(input logic [23:0] a, input logic [23:0] b,
                     input logic [23:0] e);
    @(posedge mclk_in);
    res_valid_in <= 1'b1;
    res_a_in <= a;
    res_b_in <= b;
    @(posedge mclk_in);
    res_valid_in <= 1'b0;
    #1 check(res_sum_out, e);
    check(24'(res_valid_out), 24'h000001);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    rows = '{'{8'h10, 8'h00, 2'h3, 20'h02000, 9'h003, 8'h03},
             '{8'h10, 8'h00, 2'h3, 20'h01FFF, 9'h004, 8'h00},
             '{8'h12, 8'h00, 2'h3, 20'h0C000, 9'h002, 8'h02},
             '{8'h14, 8'h00, 2'h3, 20'h05FFF, 9'h002, 8'h00},
             '{8'h16, 8'h00, 2'h3, 20'h08000, 9'h005, 8'h05},
             '{8'h16, 8'h00, 2'h3, 20'h07FFE, 9'h002, 8'h00},
             '{8'h02, 8'h00, 2'h3, 20'h04000, 9'h004, 8'h04},
             '{8'h0C, 8'h00, 2'h3, 20'h06000, 9'h001, 8'h01},
             '{8'h19, 8'h00, 2'h0, 20'h08000, 9'h006, 8'h06},
             '{8'h11, 8'h01, 2'h1, 20'hF7FFF, 9'h002, 8'h02},
             '{8'h11, 8'h02, 2'h2, 20'h08000, 9'h003, 8'h03},
             '{8'h11, 8'h02, 2'h0, 20'h08000, 9'h003, 8'h00},
             '{8'h11, 8'h03, 2'h1, 20'h08000, 9'h003, 8'h00},
             '{8'h11, 8'h00, 2'h3, 20'h07FFF, 9'h003, 8'h00},
             '{8'h10, 8'h00, 2'h0, 20'h08000, 9'h003, 8'h00}};
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(ADDR_COUNT);
    check8(got, COUNT_RESET);
    rd(5'h00);
    check8(got, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(ADDR_OVF_SEL, rows[i].osel);
      wr(ADDR_MON_CTRL, rows[i].ctrl);
      rd(ADDR_OVF_SEL);
      check8(got, rows[i].osel);
      rd(ADDR_MON_CTRL);
      check8(got, rows[i].ctrl);
      do_sync(rows[i].ctrl[4:3]);
      feed(rows[i].pt, rows[i].val, rows[i].n);
      repeat (2) @(posedge mclk_in);
      do_sync(rows[i].ctrl[4:3]);
      rd(ADDR_COUNT);
      check8(got, prev);
      rd(ADDR_COUNT);
      check8(got, rows[i].cnt);
      prev = rows[i].cnt;
      $display("test row %0d done", i);
    end
    // unselected syncs must not capture a saturated count
    wr(ADDR_MON_CTRL, 8'h10);
    do_sync(SYNC_ONE_SHOT);
    feed(2'h3, 20'h07FFF, 300);
    do_sync(SYNC_TERMINAL);
    do_sync(SYNC_PIN_A);
    do_sync(SYNC_ONE_SHOT);
    rd(ADDR_COUNT);
    check8(got, prev);
    rd(ADDR_COUNT);
    check8(got, COUNT_MAX);
    $display("test saturate done");
    sat(20'h08000, POS_FULL);
    sat(20'hF7FFF, NEG_FULL);
    sat(20'h07FFF, 16'h7FFF);
    sat(20'hF8000, 16'h8000);
    sat(20'h00123, 16'h0123);
    $display("test stages done");
    res(24'h7FFFFF, 24'h000001, RES_POS_FULL);
    rd(ADDR_STATUS);
    check8(got & 8'h01, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    res(24'h000001, 24'h000002, 24'h000003);
    rd(ADDR_STATUS);
    check8(got & 8'h01, 8'h00);
    res(24'h800000, 24'hFFFFFF, RES_NEG_FULL);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS);
    check8(got & 8'h01, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS);
    check8(got & 8'h01, 8'h00);
    $display("test resampler done");
    // hold and readable both carry 255 going into this reset
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(ADDR_COUNT);
    check8(got, COUNT_RESET);
    rd(ADDR_COUNT);
    check8(got, COUNT_RESET);
    $display("test second reset done");
    complete_run();
  end
endmodule // tb_peak_monitor
`default_nettype wire
